//--- iocr_pkg.sv
/*
 * Constants shared by the inertial output and command register bank:
 * register byte addresses, command bit positions, reset values, timing.
 * Assumes a 10 MHz system clock and a 7-bit serial register address.
 */
package iocr_pkg;

   // System clock rate in hertz
   localparam int unsigned CLK_HZ = 10000000;

   // Byte addresses of the lower byte of each 16-bit register
   localparam logic [6:0] ADDR_RATE_X = 7'h04;
   localparam logic [6:0] ADDR_RATE_Y = 7'h06;
   localparam logic [6:0] ADDR_RATE_Z = 7'h08;
   localparam logic [6:0] ADDR_ACCEL_X = 7'h0a;
   localparam logic [6:0] ADDR_ACCEL_Y = 7'h0c;
   localparam logic [6:0] ADDR_ACCEL_Z = 7'h0e;
   localparam logic [6:0] ADDR_TEMP = 7'h18;
   localparam logic [6:0] ADDR_RANGE_CTRL = 7'h38;
   localparam logic [6:0] ADDR_GLOBAL_CMD = 7'h3e;

   // Reset and factory values
   localparam logic [15:0] GLOBAL_CMD_RESET = 16'h0000;
   localparam logic [15:0] RANGE_CTRL_FACTORY = 16'h0402;
   localparam logic [15:0] READ_UNMAPPED = 16'h0000;

   // Command bit positions in the global command register
   localparam int unsigned CMD_BIAS_BIT = 0;
   localparam int unsigned CMD_FACTORY_BIT = 1;
   localparam int unsigned CMD_FLASH_BIT = 3;
   localparam int unsigned CMD_SWRESET_BIT = 7;
   // Bits that start a function; all others are ignored
   localparam logic [7:0] CMD_USED_MASK = 8'h8b;

   // Temperature field width; upper bits read as zero
   localparam int unsigned TEMP_BITS = 12;

   // Serial frame layout
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned FRAME_WRITE_BIT = 15;

   // Flash backup time in milliseconds and its cycle count
   localparam int unsigned FLASH_BACKUP_MS = 75;
   localparam int unsigned FLASH_BACKUP_CYCLES = CLK_HZ / 1000 * FLASH_BACKUP_MS;

   // Sample rate in tenths of a sample per second (819.2 SPS)
   localparam int unsigned SAMPLE_RATE_DSPS = 8192;
   localparam int unsigned SAMPLE_CYCLES = CLK_HZ * 10 / SAMPLE_RATE_DSPS;

   // Width of the shared wait counter
   localparam int unsigned TIMER_BITS = 24;

   // Command sequencer states
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_FACTORY = 3'b001,
      SEQ_BIAS = 3'b010,
      SEQ_FLASH = 3'b011,
      SEQ_RELOAD = 3'b100
   } iocr_seq_e;

endpackage : iocr_pkg

//--- iocr_spi_port.sv
/*
 * Mode-3 serial slave port: synchronises chip select, serial clock and
 * data in, shifts 16-bit frames MSB first, returns a word per frame.
 * Assumes the serial clock is far slower than the system clock.
 */
`timescale 1ns/1ps
module iocr_spi_port
   import iocr_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Serial pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // Frame side
   output logic frame_valid,
   output logic [15:0] frame_word,
   input wire logic [15:0] tx_word
);

   logic [2:0] cs_sync_reg; // Chip select synchroniser and edge stage
   logic [2:0] sclk_sync_reg; // Serial clock synchroniser and edge stage
   logic [1:0] mosi_sync_reg; // Data in synchroniser
   logic [15:0] rx_reg; // Receive shifter
   logic [15:0] tx_reg; // Transmit shifter
   logic [4:0] bit_cnt_reg; // Bits taken in this frame
   logic sel; // Chip select active
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;

   assign sel = ~cs_sync_reg[1];
   assign cs_fall = cs_sync_reg[2] & ~cs_sync_reg[1];
   assign sclk_rise = ~sclk_sync_reg[2] & sclk_sync_reg[1];
   assign sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];

   // Two-flop synchronisers, plus one edge stage on chip select and serial clock
   always_ff @(posedge clk) begin
      if (reset) begin
         cs_sync_reg <= 3'h7;
         sclk_sync_reg <= 3'h7;
         mosi_sync_reg <= 2'h0;
      end else begin
         cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
         sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
         mosi_sync_reg <= {mosi_sync_reg[0], mosi};
      end
   end

   // Receive: sample on rising serial clock, count to a full frame
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_reg <= 16'h0000;
         bit_cnt_reg <= 5'h00;
         frame_valid <= 1'b0;
         frame_word <= 16'h0000;
      end else begin
         frame_valid <= 1'b0;
         if (!sel) begin
            // Partial frames are dropped
            bit_cnt_reg <= 5'h00;
         end else if (sclk_rise) begin
            rx_reg <= {rx_reg[14:0], mosi_sync_reg[1]};
            if (bit_cnt_reg == 5'(FRAME_BITS - 1)) begin
               bit_cnt_reg <= 5'h00;
               frame_valid <= 1'b1;
               frame_word <= {rx_reg[14:0], mosi_sync_reg[1]};
            end else begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
         end
      end
   end

   // Transmit: load at frame start, shift on falling serial clock
   always_ff @(posedge clk) begin
      if (reset) begin
         tx_reg <= 16'h0000;
         miso <= 1'b0;
         miso_oe <= 1'b0;
      end else begin
         miso_oe <= sel;
         if (cs_fall || (sel && sclk_fall && bit_cnt_reg == 5'h00)) begin
            tx_reg <= {tx_word[14:0], 1'b0};
            miso <= tx_word[15];
         end else if (sel && sclk_fall) begin
            tx_reg <= {tx_reg[14:0], 1'b0};
            miso <= tx_reg[15];
         end
      end
   end

endmodule : iocr_spi_port

//--- iocr_regs.sv
/*
 * Register bank of a six-axis inertial module: sensor output registers,
 * one flash-mirrored control register and the global command register
 * with its self-clearing command sequencer, reached over a mode-3
 * serial slave port.
 * Assumes sensor inputs and the flash macro share the system clock;
 * the serial pins come from outside and are synchronised here.
 */
// How it works
// - Control writes change only the working copy
// - Command 0xBE08 backs up, takes 75 ms
// - Mirrored registers reload from flash after reset
// - Rate outputs twos complement, 100 LSB per deg/s
// - Rate outputs read-only at 0x04, 0x06, 0x08
// - Acceleration outputs twos complement, 4000 per g
// - Acceleration outputs read-only at 0x0A, 0x0C, 0x0E
// - Temperature is 12-bit, upper four bits zero
// - Temperature read-only at 0x18
// - Command register write-only at 0x3E, resets zero
// - Writing one starts a function, zero nothing
// - Command bit clears itself when function ends
// - Bit 7 starts a software reset
// - Bits 3, 1, 0: flash, factory, bias
// - Reload control from flash before new data
// - Registers two bytes wide, written byte-wise
// - Read takes two frames; answer in second
// - Outputs update at 819.2 SPS without setup
`timescale 1ns/1ps
module iocr_regs
   import iocr_pkg::*;
#(
   parameter int unsigned FLASH_CYCLES = FLASH_BACKUP_CYCLES,
   parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES,
   parameter int unsigned RELOAD_CYCLES = 16,
   parameter int unsigned BIAS_CYCLES = 16
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Serial pins
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic MOSI,
   output logic MISO,
   output logic MISO_OE,
   // Sensor front end samples
   input wire logic [15:0] RATE_X_IN,
   input wire logic [15:0] RATE_Y_IN,
   input wire logic [15:0] RATE_Z_IN,
   input wire logic [15:0] ACCEL_X_IN,
   input wire logic [15:0] ACCEL_Y_IN,
   input wire logic [15:0] ACCEL_Z_IN,
   input wire logic [11:0] TEMP_IN,
   // Control to the front end
   output logic [7:0] RANGE_SEL,
   output logic [7:0] FILTER_SEL,
   output logic BIAS_NULL_START,
   output logic SAMPLE_STROBE,
   // Flash mirror macro
   input wire logic [15:0] FLASH_RD_DATA,
   output logic FLASH_WR_EN,
   output logic [15:0] FLASH_WR_DATA
);

   // Serial port wiring
   logic frame_valid;
   logic [15:0] frame_word;
   logic [15:0] read_word_reg; // Answer for the next frame
   logic miso_int;
   logic miso_oe_int;

   // Register storage
   logic [15:0] rate_x_out_reg;
   logic [15:0] rate_y_out_reg;
   logic [15:0] rate_z_out_reg;
   logic [15:0] accel_x_out_reg;
   logic [15:0] accel_y_out_reg;
   logic [15:0] accel_z_out_reg;
   logic [15:0] die_temperature_out_reg;
   logic [15:0] range_ctrl_reg; // Volatile working copy
   logic [15:0] range_ctrl_next;
   logic [15:0] global_command_reg;
   logic [15:0] global_command_next;

   // Sequencer and timers
   iocr_seq_e seq_reg;
   logic [TIMER_BITS-1:0] wait_cnt_reg; // Cycles left in current step
   logic [TIMER_BITS-1:0] sample_cnt_reg; // Sample period divider
   logic [15:0] cmd_clear; // Bits finished this cycle
   logic wr_hit; // Frame is a byte write
   logic [6:0] frame_addr;
   logic [7:0] frame_data;
   logic sample_tick;

   assign wr_hit = frame_valid & frame_word[FRAME_WRITE_BIT];
   assign frame_addr = frame_word[14:8];
   assign frame_data = frame_word[7:0];

   // Same word address, ignoring the byte select bit
   function automatic logic word_match(input logic [6:0] a,
                                       input logic [6:0] base);
      word_match = (a[6:1] == base[6:1]);
   endfunction : word_match

   // Merge one written byte into a 16-bit word
   function automatic logic [15:0] byte_merge(input logic [15:0] old,
                                              input logic [6:0] a,
                                              input logic [7:0] d);
      byte_merge = a[0] ? {d, old[7:0]} : {old[15:8], d};
   endfunction : byte_merge

   // Read decode; the command register is write-only and reads zero
   function automatic logic [15:0] read_decode(input logic [6:0] a);
      read_decode = READ_UNMAPPED;
      if (word_match(a, ADDR_RATE_X)) read_decode = rate_x_out_reg;
      if (word_match(a, ADDR_RATE_Y)) read_decode = rate_y_out_reg;
      if (word_match(a, ADDR_RATE_Z)) read_decode = rate_z_out_reg;
      if (word_match(a, ADDR_ACCEL_X)) read_decode = accel_x_out_reg;
      if (word_match(a, ADDR_ACCEL_Y)) read_decode = accel_y_out_reg;
      if (word_match(a, ADDR_ACCEL_Z)) read_decode = accel_z_out_reg;
      if (word_match(a, ADDR_TEMP)) read_decode = die_temperature_out_reg;
      if (word_match(a, ADDR_RANGE_CTRL)) read_decode = range_ctrl_reg;
   endfunction : read_decode

   // Serial slave port
   iocr_spi_port u_spi (
      .clk(CLK),
      .reset(RESET),
      .cs_n(CS_N),
      .sclk(SCLK),
      .mosi(MOSI),
      .miso(miso_int),
      .miso_oe(miso_oe_int),
      .frame_valid(frame_valid),
      .frame_word(frame_word),
      .tx_word(read_word_reg)
   );

   // Pin outputs come straight from the port's flops
   assign MISO = miso_int;
   assign MISO_OE = miso_oe_int;

   // Read request captured now, shifted out in the next frame
   always_ff @(posedge CLK) begin
      if (RESET) begin
         read_word_reg <= 16'h0000;
      end else if (frame_valid && !frame_word[FRAME_WRITE_BIT]) begin
         read_word_reg <= read_decode(frame_addr);
      end
   end

   // Working copy of the range and filter control register
   always_comb begin
      range_ctrl_next = range_ctrl_reg;
      if (wr_hit && word_match(frame_addr, ADDR_RANGE_CTRL)) begin
         range_ctrl_next = byte_merge(range_ctrl_reg, frame_addr,
            frame_data);
      end
      if (seq_reg == SEQ_FACTORY) begin
         range_ctrl_next = RANGE_CTRL_FACTORY;
      end
      if (seq_reg == SEQ_RELOAD) begin
         range_ctrl_next = FLASH_RD_DATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         range_ctrl_reg <= RANGE_CTRL_FACTORY;
      end else begin
         range_ctrl_reg <= range_ctrl_next;
      end
   end

   // Command register: host sets, sequencer clears, set wins
   always_comb begin
      global_command_next = global_command_reg & ~cmd_clear;
      if (wr_hit && frame_addr == ADDR_GLOBAL_CMD) begin
         global_command_next[7:0] = global_command_next[7:0]
            | (frame_data & CMD_USED_MASK);
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         global_command_reg <= GLOBAL_CMD_RESET;
      end else begin
         global_command_reg <= global_command_next;
      end
   end

   // Bits finished when the sequence returns to idle
   always_comb begin
      cmd_clear = 16'h0000;
      if (seq_reg == SEQ_RELOAD && wait_cnt_reg == '0) begin
         cmd_clear[CMD_SWRESET_BIT] = 1'b1;
         cmd_clear[CMD_FLASH_BIT] = 1'b1;
         cmd_clear[CMD_FACTORY_BIT] = 1'b1;
         cmd_clear[CMD_BIAS_BIT] = 1'b1;
      end
   end

   // Command sequencer; reset enters the flash reload step first
   always_ff @(posedge CLK) begin
      if (RESET) begin
         seq_reg <= SEQ_RELOAD;
         wait_cnt_reg <= TIMER_BITS'(RELOAD_CYCLES);
      end else begin
         case (seq_reg)
            SEQ_IDLE: begin
               if (global_command_reg[CMD_SWRESET_BIT]) begin
                  seq_reg <= SEQ_RELOAD;
                  wait_cnt_reg <= TIMER_BITS'(RELOAD_CYCLES);
               end else if (global_command_reg[CMD_FACTORY_BIT]) begin
                  seq_reg <= SEQ_FACTORY;
                  wait_cnt_reg <= '0;
               end else if (global_command_reg[CMD_BIAS_BIT]) begin
                  seq_reg <= SEQ_BIAS;
                  wait_cnt_reg <= TIMER_BITS'(BIAS_CYCLES);
               end else if (global_command_reg[CMD_FLASH_BIT]) begin
                  seq_reg <= SEQ_FLASH;
                  wait_cnt_reg <= TIMER_BITS'(FLASH_CYCLES);
               end
            end
            SEQ_FACTORY, SEQ_BIAS: begin
               // Finished calibration functions end with a backup
               if (wait_cnt_reg == '0) begin
                  seq_reg <= SEQ_FLASH;
                  wait_cnt_reg <= TIMER_BITS'(FLASH_CYCLES);
               end else begin
                  wait_cnt_reg <= wait_cnt_reg - 1'b1;
               end
            end
            SEQ_FLASH: begin
               // Hold for the whole backup time, then reload
               if (wait_cnt_reg == '0) begin
                  seq_reg <= SEQ_RELOAD;
                  wait_cnt_reg <= TIMER_BITS'(RELOAD_CYCLES);
               end else begin
                  wait_cnt_reg <= wait_cnt_reg - 1'b1;
               end
            end
            SEQ_RELOAD: begin
               if (wait_cnt_reg == '0) begin
                  seq_reg <= SEQ_IDLE;
               end else begin
                  wait_cnt_reg <= wait_cnt_reg - 1'b1;
               end
            end
            default: begin
               seq_reg <= SEQ_RELOAD;
               wait_cnt_reg <= TIMER_BITS'(RELOAD_CYCLES);
            end
         endcase
      end
   end

   // Flash write strobe at the start of a backup
   always_ff @(posedge CLK) begin
      if (RESET) begin
         FLASH_WR_EN <= 1'b0;
         FLASH_WR_DATA <= 16'h0000;
      end else begin
         FLASH_WR_EN <= (seq_reg == SEQ_FLASH)
            && (wait_cnt_reg == TIMER_BITS'(FLASH_CYCLES));
         FLASH_WR_DATA <= range_ctrl_reg;
      end
   end

   // Bias null request to the front end, one pulse
   always_ff @(posedge CLK) begin
      if (RESET) begin
         BIAS_NULL_START <= 1'b0;
      end else begin
         BIAS_NULL_START <= (seq_reg == SEQ_BIAS)
            && (wait_cnt_reg == TIMER_BITS'(BIAS_CYCLES));
      end
   end

   // Range and filter settings driven to the front end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         RANGE_SEL <= RANGE_CTRL_FACTORY[15:8];
         FILTER_SEL <= RANGE_CTRL_FACTORY[7:0];
      end else begin
         RANGE_SEL <= range_ctrl_reg[15:8];
         FILTER_SEL <= range_ctrl_reg[7:0];
      end
   end

   // Sample period divider, free running from reset
   assign sample_tick = (sample_cnt_reg == '0);

   always_ff @(posedge CLK) begin
      if (RESET) begin
         sample_cnt_reg <= TIMER_BITS'(SAMPLE_PERIOD - 1);
         SAMPLE_STROBE <= 1'b0;
      end else begin
         if (sample_tick) begin
            sample_cnt_reg <= TIMER_BITS'(SAMPLE_PERIOD - 1);
         end else begin
            sample_cnt_reg <= sample_cnt_reg - 1'b1;
         end
         SAMPLE_STROBE <= sample_tick && (seq_reg == SEQ_IDLE);
      end
   end

   // Output registers load only from the front end, never from writes
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rate_x_out_reg <= 16'h0000;
         rate_y_out_reg <= 16'h0000;
         rate_z_out_reg <= 16'h0000;
         accel_x_out_reg <= 16'h0000;
         accel_y_out_reg <= 16'h0000;
         accel_z_out_reg <= 16'h0000;
         die_temperature_out_reg <= 16'h0000;
      end else if (sample_tick && seq_reg == SEQ_IDLE) begin
         rate_x_out_reg <= RATE_X_IN;
         rate_y_out_reg <= RATE_Y_IN;
         rate_z_out_reg <= RATE_Z_IN;
         accel_x_out_reg <= ACCEL_X_IN;
         accel_y_out_reg <= ACCEL_Y_IN;
         accel_z_out_reg <= ACCEL_Z_IN;
         die_temperature_out_reg <= {{(16 - TEMP_BITS){1'b0}},
            TEMP_IN};
      end
   end

endmodule : iocr_regs

//--- iocr_regs_assertions.sv
/*
 * Checker for the register bank: pulses, backup, reload, enable and
 * sample spacing.
 * Assumes it is bound to iocr_regs and sees only that module's ports.
 */
`timescale 1ns/1ps
module iocr_regs_assertions
   import iocr_pkg::*;
#(
   parameter int unsigned FLASH_CYCLES = FLASH_BACKUP_CYCLES,
   parameter int unsigned SAMPLE_PERIOD = SAMPLE_CYCLES,
   parameter int unsigned RELOAD_CYCLES = 16,
   parameter int unsigned BIAS_CYCLES = 16
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // Serial select and data-out enable
   input wire logic CS_N,
   input wire logic MISO_OE,
   // Control and pulses
   input wire logic [7:0] RANGE_SEL,
   input wire logic [7:0] FILTER_SEL,
   input wire logic BIAS_NULL_START,
   input wire logic SAMPLE_STROBE,
   // Flash mirror
   input wire logic [15:0] FLASH_RD_DATA,
   input wire logic FLASH_WR_EN,
   input wire logic [15:0] FLASH_WR_DATA
);
   // Bias pulse to backup window
   localparam int BIAS_LO = BIAS_CYCLES - 2;
   localparam int BIAS_HI = BIAS_CYCLES + 8;

   logic [31:0] busy_cnt_reg; // Cycles left with no sample allowed
   logic [31:0] gap_reg; // Cycles since the last sample strobe
   logic seen_reg; // A strobe has been seen since reset

   // Quiet window opened by each backup pulse
   always_ff @(posedge CLK) begin
      if (RESET) begin
         busy_cnt_reg <= 32'h0;
      end else if (FLASH_WR_EN) begin
         busy_cnt_reg <= FLASH_CYCLES;
      end else if (busy_cnt_reg != 32'h0) begin
         busy_cnt_reg <= busy_cnt_reg - 32'h1;
      end
   end

   // Distance between sample strobes
   always_ff @(posedge CLK) begin
      if (RESET) begin
         gap_reg <= 32'h0;
         seen_reg <= 1'b0;
      end else if (SAMPLE_STROBE) begin
         gap_reg <= 32'h1;
         seen_reg <= 1'b1;
      end else begin
         gap_reg <= gap_reg + 32'h1;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);

   a_flash_single: assert property (
      FLASH_WR_EN |=> !FLASH_WR_EN [*8])
      else $error("backup pulse repeated");
   a_bias_single: assert property (
      BIAS_NULL_START |=> !BIAS_NULL_START [*4])
      else $error("bias start pulse too long");
   a_backup_value: assert property (
      FLASH_WR_EN |-> FLASH_WR_DATA == {RANGE_SEL, FILTER_SEL})
      else $error("backup word is not the working copy");
   a_no_sample_busy: assert property (
      SAMPLE_STROBE |-> busy_cnt_reg == 32'h0)
      else $error("sample loaded during backup");
   a_bias_to_flash: assert property (
      BIAS_NULL_START |-> ##[BIAS_LO:BIAS_HI] FLASH_WR_EN)
      else $error("no backup after bias correction");
   a_boot_reload: assert property (
      $fell(RESET) |-> ##[1:4] ({RANGE_SEL, FILTER_SEL} == FLASH_RD_DATA))
      else $error("control not reloaded after reset");
   a_oe_select: assert property (
      (!CS_N && !RESET) [*5] |-> MISO_OE)
      else $error("data out not enabled while selected");
   a_oe_release: assert property (
      (CS_N && !RESET) [*5] |-> !MISO_OE)
      else $error("data out driven while deselected");
   a_sample_spacing: assert property (
      SAMPLE_STROBE && seen_reg |-> gap_reg >= SAMPLE_PERIOD - 1)
      else $error("samples closer than the period");
endmodule : iocr_regs_assertions

bind iocr_regs iocr_regs_assertions #(
   .FLASH_CYCLES(FLASH_CYCLES),
   .SAMPLE_PERIOD(SAMPLE_PERIOD),
   .RELOAD_CYCLES(RELOAD_CYCLES),
   .BIAS_CYCLES(BIAS_CYCLES)
) u_chk (
   .CLK(CLK), .RESET(RESET), .CS_N(CS_N), .MISO_OE(MISO_OE),
   .RANGE_SEL(RANGE_SEL), .FILTER_SEL(FILTER_SEL),
   .BIAS_NULL_START(BIAS_NULL_START), .SAMPLE_STROBE(SAMPLE_STROBE),
   .FLASH_RD_DATA(FLASH_RD_DATA), .FLASH_WR_EN(FLASH_WR_EN),
   .FLASH_WR_DATA(FLASH_WR_DATA)
);

//--- iocr_host_model.sv
/*
 * Host model: mode-3 serial master, 16-bit frames MSB first, serial
 * clock of 8 system clocks, held high between frames.
 * Assumes the bench calls frame() and the device drives its data-out
 * line only while the enable is high.
 */
`timescale 1ns/1ps
module iocr_host_model (
   // Clock
   input wire logic clk,
   // Serial pins
   output logic cs_n,
   output logic sclk,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   logic miso_seen; // Data-out line as the host sees it

   // Deselected, clock idle high
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      mosi = 1'b0;
   end

   assign miso_seen = miso_oe ? miso : ~miso; // Released line inverts

   // One frame: select, 16 clock periods, deselect
   task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
      @(negedge clk);
      cs_n = 1'b0;
      repeat (4) @(negedge clk);
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b0; // Data changes on the falling edge
         mosi = tx[i];
         repeat (4) @(negedge clk);
         sclk = 1'b1; // Device takes the bit on the rising edge
         repeat (3) @(negedge clk);
         rx[i] = miso_seen;
         @(negedge clk);
      end
      cs_n = 1'b1;
      mosi = ~mosi; // Line no longer holds the last bit
      repeat (8) @(negedge clk);
   endtask : frame
endmodule : iocr_host_model

//--- iocr_regs_tb.sv
/*
 * Testbench of the register bank: host model, flash model and random
 * sensor samples; checks output reads, control writes and commands.
 * Assumes the package, the host model and the bound checker.
 */
`timescale 1ns/1ps
module iocr_regs_tb;
   import iocr_pkg::*;
   localparam int unsigned FLASH_N = 40; // Shortened backup time
   localparam int unsigned SAMPLE_N = 400; // Shortened sample period
   logic clk = 1'b0; // System clock
   logic reset = 1'b1; // Synchronous reset
   wire cs_n, sclk, mosi; // Serial pins from the host
   logic miso, miso_oe, bias_start, strobe, flash_we;
   logic [15:0] rx, ry, rz, ax, ay, az, flash_wd;
   logic [11:0] tp; // Temperature sample
   logic [7:0] range_sel, filter_sel;
   logic [15:0] flash_mem = 16'h0813; // Nonvolatile control copy
   logic [31:0] seed = 32'h0000a092; // Random state
   int n_mismatch = 0;
   int samples_checked = 0;
   int n_flash = 0; // Backup pulses seen
   int n_bias = 0; // Bias start pulses seen
   logic [6:0] outs [7] = '{ADDR_RATE_X, ADDR_RATE_Y, ADDR_RATE_Z,
      ADDR_ACCEL_X, ADDR_ACCEL_Y, ADDR_ACCEL_Z, ADDR_TEMP};
   logic [7:0] cmds [5] = '{8'h08, 8'h80, 8'h02, 8'h01, 8'h74};

   // Clock
   always #50 clk = ~clk;

   iocr_regs #(.FLASH_CYCLES(FLASH_N), .SAMPLE_PERIOD(SAMPLE_N)) u_dut (
      .CLK(clk), .RESET(reset), .CS_N(cs_n), .SCLK(sclk), .MOSI(mosi),
      .MISO(miso), .MISO_OE(miso_oe), .RATE_X_IN(rx), .RATE_Y_IN(ry),
      .RATE_Z_IN(rz), .ACCEL_X_IN(ax), .ACCEL_Y_IN(ay), .ACCEL_Z_IN(az),
      .TEMP_IN(tp), .RANGE_SEL(range_sel), .FILTER_SEL(filter_sel),
      .BIAS_NULL_START(bias_start), .SAMPLE_STROBE(strobe),
      .FLASH_RD_DATA(flash_mem), .FLASH_WR_EN(flash_we),
      .FLASH_WR_DATA(flash_wd));

   iocr_host_model u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk),
      .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

   // Flash model and pulse counters
   always @(posedge clk) begin
      if (flash_we) begin
         flash_mem <= flash_wd;
         n_flash <= n_flash + 1;
      end
      if (bias_start) begin
         n_bias <= n_bias + 1;
      end
   end

   // Xorshift generator
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction : rnd

   // Expected word of an output register
   function automatic logic [15:0] exp_out(input logic [6:0] a);
      case (a)
         ADDR_RATE_X: return rx;
         ADDR_RATE_Y: return ry;
         ADDR_RATE_Z: return rz;
         ADDR_ACCEL_X: return ax;
         ADDR_ACCEL_Y: return ay;
         ADDR_ACCEL_Z: return az;
         ADDR_TEMP: return {4'h0, tp};
         default: return READ_UNMAPPED;
      endcase
   endfunction : exp_out

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] want,
         input string what);
      samples_checked++;
      if (seen !== want) begin
         n_mismatch++;
         $display("FAIL %0t %s: %h not %h", $time, what, seen, want);
      end
   endtask : check

   // Verdict and end of run
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // Wait for a sample strobe, bounded
   task automatic wait_strobe();
      for (int i = 0; i < 600; i++) begin
         @(negedge clk);
         if (strobe === 1'b1) begin
            return;
         end
      end
      n_mismatch++;
      $display("FAIL %0t no sample strobe", $time);
      complete_run();
   endtask : wait_strobe

   // Byte write, word write and two-frame read
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] junk;
      u_host.frame({1'b1, a, d}, junk);
   endtask : wr
   task automatic wr16(input logic [6:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a | 7'h01, v[15:8]);
   endtask : wr16
   task automatic rd(input logic [6:0] a, output logic [15:0] d);
      logic [15:0] junk;
      u_host.frame({1'b0, a, 8'h00}, junk);
      u_host.frame(16'h0000, d);
   endtask : rd

   // Sensor samples: zero, extremes, then random
   task automatic set_inputs(input int r);
      if (r == 0) begin
         {rx, ry, rz, ax, ay, az, tp} = '0;
      end else if (r == 1) begin
         {rx, ry, rz} = {16'h61a8, 16'h9e58, 16'hffff};
         {ax, ay, az, tp} = {16'h4e20, 16'hb1e0, 16'hfffe, 12'hc3e};
      end else begin
         {rx, ry, rz} = {rnd(), rnd(), rnd()};
         {ax, ay, az, tp} = {rnd(), rnd(), rnd(), 12'(rnd())};
      end
   endtask : set_inputs

   // Main sequence
   initial begin
      logic [15:0] d, v, f0;
      int nf, nb, r, i;
      set_inputs(0);
      repeat (4) @(negedge clk);
      check({range_sel, filter_sel}, RANGE_CTRL_FACTORY, "reset");
      reset = 1'b0;
      repeat (30) @(negedge clk);
      check({range_sel, filter_sel}, 16'h0813, "boot reload");
      // Outputs: a stray write to each, then a read
      for (r = 0; r < 4; r++) begin
         set_inputs(r);
         for (i = 0; i < 7; i++) begin
            wait_strobe();
            wr(outs[i] | 7'(r & 1), 8'(rnd()));
            rd(outs[i], d);
            check(d, exp_out(outs[i]), "output");
         end
      end
      // Control write reaches only the working copy
      wr16(ADDR_RANGE_CTRL, 16'h0755);
      check({range_sel, filter_sel}, 16'h0755, "ctrl write");
      check(flash_mem, 16'h0813, "no backup");
      rd(ADDR_GLOBAL_CMD, d);
      check(d, GLOBAL_CMD_RESET, "cmd read");
      // Every command bit and the unused bits
      for (i = 0; i < 5; i++) begin
         v = rnd();
         wr16(ADDR_RANGE_CTRL, v);
         f0 = flash_mem;
         nf = n_flash;
         nb = n_bias;
         wr(ADDR_GLOBAL_CMD, cmds[i]);
         wait_strobe();
         wait_strobe();
         if (cmds[i] == 8'h02) begin
            v = RANGE_CTRL_FACTORY; // Factory restore
         end
         if ((cmds[i] & 8'h0b) != 8'h00) begin
            f0 = v; // Backup taken
         end
         if (cmds[i] == 8'h80) begin
            v = f0; // Reload only
         end
         check({range_sel, filter_sel}, v, "ctrl");
         check(flash_mem, f0, "flash");
         check(16'(n_flash - nf), 16'(|(cmds[i] & 8'h0b)), "backups");
         check(16'(n_bias - nb), {15'h0, cmds[i][0]}, "bias");
      end
      complete_run();
   end
endmodule : iocr_regs_tb
